// >>> inc/ccl_pkg.sv
// Shared constants, types and decode for the coefficient and configuration load ports
package ccl_pkg;
  localparam int WORD_W = 12;
  localparam int CLASS_HI = 11;
  localparam int CLASS_LO = 9;
  localparam int INDEX_W = 9;
  localparam int ROW_W = 8;
  localparam int REG_IDX_W = 4;
  localparam int NUM_BANKS = 8;
  localparam int NUM_ROWS = 256;
  localparam int NUM_REGS = 16;
  localparam int NUM_PORTS = 2;
  localparam int SEL_W = 5;
  localparam int CTL_W = 32;
  localparam int BYTE_W = 8;
  localparam int ROW_BITS = NUM_BANKS * WORD_W;
  localparam int POS_W = 4;
  localparam int LIMIT_CFG_W = 2;
  localparam int MODE_CFG_W = 6;

  typedef enum logic [2:0] {
    CCL_COEF = 3'h0,
    CCL_CFG = 3'h1,
    CCL_SEL_FIRST = 3'h2,
    CCL_SEL_SECOND = 3'h3,
    CCL_RND_FIRST = 3'h4,
    CCL_RND_SECOND = 3'h5,
    CCL_LIM_FIRST = 3'h6,
    CCL_LIM_SECOND = 3'h7
  } ccl_class_t;

  localparam logic [POS_W-1:0] WORDS_COEF = 4'h8;
  localparam logic [POS_W-1:0] WORDS_ONE = 4'h1;
  localparam logic [POS_W-1:0] WORDS_WIDE = 4'h4;

  localparam logic [WORD_W-1:0] ADDR_LIMIT_CFG = 12'h0204;
  localparam logic [WORD_W-1:0] ADDR_MODE_CFG = 12'h0205;
  localparam logic [LIMIT_CFG_W-1:0] LIMIT_CFG_RESET = 2'h0;
  localparam logic [MODE_CFG_W-1:0] MODE_CFG_RESET = 6'h00;
  localparam logic [WORD_W-1:0] WORD_IDLE = 12'h000;

  localparam int LIM_SECOND_BIT = 0;
  localparam int LIM_FIRST_BIT = 1;
  localparam int MODE_CASCADE_BIT = 0;
  localparam int MODE_DUAL_BIT = 1;
  localparam int MODE_B_PRIMARY_BIT = 2;
  localparam int MODE_B_SCALE_BIT = 3;
  localparam int MODE_MATRIX_BIT = 4;
  localparam int MODE_ACCUM_BIT = 5;

  // Data words that follow the address word for a target class
  function automatic logic [POS_W-1:0] ccl_words_needed(input ccl_class_t cls);
    logic [POS_W-1:0] n;
    n = WORDS_ONE;
    unique case (cls)
      CCL_COEF: n = WORDS_COEF;
      CCL_CFG, CCL_SEL_FIRST, CCL_SEL_SECOND: n = WORDS_ONE;
      CCL_RND_FIRST, CCL_RND_SECOND, CCL_LIM_FIRST, CCL_LIM_SECOND: n = WORDS_WIDE;
    endcase
    return n;
  endfunction
endpackage

// >>> inc/ccl_load_if.sv
// Twin word-serial load ports between host and filter device
interface ccl_load_if;
  logic load_enable_first_n;
  logic [11:0] load_word_first;
  logic hold_first;
  logic load_enable_second_n;
  logic [11:0] load_word_second;
  logic hold_second;

  modport device (
    input load_enable_first_n,
    input load_word_first,
    input hold_first,
    input load_enable_second_n,
    input load_word_second,
    input hold_second
  );

  modport host (
    output load_enable_first_n,
    output load_word_first,
    output hold_first,
    output load_enable_second_n,
    output load_word_second,
    output hold_second
  );
endinterface

// >>> hw/ccl_loader_dev.sv
// Device end: load port sequencers, coefficient banks, control and config registers
// Functional notes
// - Words taken only while load enable low
// - Address word: class bits 11-9, index 8-0
// - Address presented on enable falling-edge cycle
// - Coefficient address takes eight words, banks 0-7
// - Config or select address takes one word
// - Round or limit address takes four words
// - Hold high freezes the sequence in place
// - Second port identical, serves second filter banks
// - Coefficient row loads in nine cycles
// - Round or limit register loads in five cycles
// - Storage written only after all words received
// - Config 4: bit0 second, bit1 first limiting
// - Config 5 bit0: cascade position
// - Config 5 bit1 dual, bit2 second input
// - Config 5 bits 3-5: scale, matrix, accumulator
// - Class decode of address top three bits
// - New address after last word; host closes next
// - Simultaneous control writes: second port wins
module ccl_loader_dev (
  input wire logic i_clock,
  input wire logic i_rst_b,
  ccl_load_if.device lif,
  input wire logic [ccl_pkg::ROW_W-1:0] i_coef_row_first,
  input wire logic [ccl_pkg::ROW_W-1:0] i_coef_row_second,
  input wire logic [ccl_pkg::REG_IDX_W-1:0] i_reg_sel_first,
  input wire logic [ccl_pkg::REG_IDX_W-1:0] i_reg_sel_second,
  output logic [ccl_pkg::ROW_BITS-1:0] o_coef_first,
  output logic [ccl_pkg::ROW_BITS-1:0] o_coef_second,
  output logic [ccl_pkg::SEL_W-1:0] o_select_first,
  output logic [ccl_pkg::SEL_W-1:0] o_select_second,
  output logic [ccl_pkg::CTL_W-1:0] o_round_first,
  output logic [ccl_pkg::CTL_W-1:0] o_round_second,
  output logic [ccl_pkg::CTL_W-1:0] o_limit_first,
  output logic [ccl_pkg::CTL_W-1:0] o_limit_second,
  output logic o_limit_en_first,
  output logic o_limit_en_second,
  output logic o_cascade_not_last,
  output logic o_dual_mode,
  output logic o_second_in_primary,
  output logic o_second_scaled,
  output logic o_matrix_mode,
  output logic o_accum_mode
);
  import ccl_pkg::*;

  logic port_en_n [NUM_PORTS];
  logic port_hold [NUM_PORTS];
  logic [WORD_W-1:0] port_word [NUM_PORTS];
  logic [ROW_W-1:0] row_sel [NUM_PORTS];
  logic [ROW_BITS-1:0] row_q [NUM_PORTS];
  logic commit_reg [NUM_PORTS];
  ccl_class_t cls_reg [NUM_PORTS];
  logic [INDEX_W-1:0] idx_reg [NUM_PORTS];
  logic [WORD_W-1:0] slot_reg [NUM_PORTS][NUM_BANKS];
  logic ctl_commit [NUM_PORTS];

  assign port_en_n[0] = lif.load_enable_first_n;
  assign port_hold[0] = lif.hold_first;
  assign port_word[0] = lif.load_word_first;
  assign port_en_n[1] = lif.load_enable_second_n;
  assign port_hold[1] = lif.hold_second;
  assign port_word[1] = lif.load_word_second;
  assign row_sel[0] = i_coef_row_first;
  assign row_sel[1] = i_coef_row_second;
  assign o_coef_first = row_q[0];
  assign o_coef_second = row_q[1];

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      logic [POS_W-1:0] pos_reg;
      logic [WORD_W-1:0] bank_mem [NUM_BANKS][NUM_ROWS];
      wire accept = !port_en_n[p] && !port_hold[p];
      wire [POS_W-1:0] need = ccl_words_needed(cls_reg[p]);
      wire at_addr = (pos_reg == '0);
      wire last_word = !at_addr && (pos_reg == need);
      wire [POS_W-1:0] slot_idx = pos_reg - POS_W'(1);

      assign ctl_commit[p] = commit_reg[p] && (cls_reg[p] != CCL_COEF);

      // Position counter: zero expects an address
      always_ff @(posedge i_clock or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          pos_reg <= '0;
          cls_reg[p] <= CCL_COEF;
          idx_reg[p] <= '0;
          commit_reg[p] <= 1'b0;
        end
        else
        begin
          // Commit lags the last word by one edge
          commit_reg[p] <= accept && last_word;
          if (port_en_n[p])
            pos_reg <= '0;
          else if (accept && at_addr)
          begin
            cls_reg[p] <= ccl_class_t'(port_word[p][CLASS_HI:CLASS_LO]);
            idx_reg[p] <= port_word[p][INDEX_W-1:0];
            pos_reg <= POS_W'(1);
          end
          else if (accept && last_word)
            pos_reg <= '0;
          else if (accept)
            pos_reg <= pos_reg + POS_W'(1);
        end
      end

      always_ff @(posedge i_clock or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          for (int i = 0; i < NUM_BANKS; i++)
            slot_reg[p][i] <= WORD_IDLE;
        end
        else if (accept && !at_addr)
          slot_reg[p][slot_idx[2:0]] <= port_word[p];
      end

      // Each port owns its filter's banks
      always_ff @(posedge i_clock)
      begin
        if (commit_reg[p] && cls_reg[p] == CCL_COEF)
        begin
          for (int b = 0; b < NUM_BANKS; b++)
            bank_mem[b][idx_reg[p][ROW_W-1:0]] <= slot_reg[p][b];
        end
      end

      always_ff @(posedge i_clock)
      begin
        for (int b = 0; b < NUM_BANKS; b++)
          row_q[p][b*WORD_W +: WORD_W] <= bank_mem[b][row_sel[p]];
      end
    end
  endgenerate

  // Shared control write path, second port has priority
  wire win = ctl_commit[1];
  wire ctl_we = ctl_commit[0] || ctl_commit[1];
  ccl_class_t w_cls;
  assign w_cls = cls_reg[win];
  wire [INDEX_W-1:0] w_idx = idx_reg[win];
  wire [WORD_W-1:0] w_addr = {w_cls, w_idx};
  wire [REG_IDX_W-1:0] w_reg = w_idx[REG_IDX_W-1:0];
  wire w_in_range = (w_idx[INDEX_W-1:REG_IDX_W] == '0);
  wire w_filter = w_cls[0];
  wire [WORD_W-1:0] w_first = slot_reg[win][0];
  wire [CTL_W-1:0] w_wide = {slot_reg[win][3][BYTE_W-1:0], slot_reg[win][2][BYTE_W-1:0],
                             slot_reg[win][1][BYTE_W-1:0], slot_reg[win][0][BYTE_W-1:0]};
  wire is_sel = (w_cls == CCL_SEL_FIRST) || (w_cls == CCL_SEL_SECOND);
  wire is_rnd = (w_cls == CCL_RND_FIRST) || (w_cls == CCL_RND_SECOND);
  wire is_lim = (w_cls == CCL_LIM_FIRST) || (w_cls == CCL_LIM_SECOND);

  logic [LIMIT_CFG_W-1:0] limit_cfg_reg;
  logic [MODE_CFG_W-1:0] mode_cfg_reg;
  logic [SEL_W-1:0] sel_mem [NUM_PORTS][NUM_REGS];
  logic [CTL_W-1:0] rnd_mem [NUM_PORTS][NUM_REGS];
  logic [CTL_W-1:0] lim_mem [NUM_PORTS][NUM_REGS];

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      limit_cfg_reg <= LIMIT_CFG_RESET;
      mode_cfg_reg <= MODE_CFG_RESET;
    end
    else if (ctl_we && w_addr == ADDR_LIMIT_CFG)
      limit_cfg_reg <= w_first[LIMIT_CFG_W-1:0];
    else if (ctl_we && w_addr == ADDR_MODE_CFG)
      mode_cfg_reg <= w_first[MODE_CFG_W-1:0];
  end

  always_ff @(posedge i_clock)
  begin
    if (ctl_we && w_in_range && is_sel)
      sel_mem[w_filter][w_reg] <= w_first[SEL_W-1:0];
    if (ctl_we && w_in_range && is_rnd)
      rnd_mem[w_filter][w_reg] <= w_wide;
    if (ctl_we && w_in_range && is_lim)
      lim_mem[w_filter][w_reg] <= w_wide;
  end

  // Registered reads, one cycle behind the index inputs
  always_ff @(posedge i_clock)
  begin
    o_select_first <= sel_mem[0][i_reg_sel_first];
    o_round_first <= rnd_mem[0][i_reg_sel_first];
    o_limit_first <= lim_mem[0][i_reg_sel_first];
    o_select_second <= sel_mem[1][i_reg_sel_second];
    o_round_second <= rnd_mem[1][i_reg_sel_second];
    o_limit_second <= lim_mem[1][i_reg_sel_second];
  end

  assign o_limit_en_second = limit_cfg_reg[LIM_SECOND_BIT];
  assign o_limit_en_first = limit_cfg_reg[LIM_FIRST_BIT];
  assign o_cascade_not_last = mode_cfg_reg[MODE_CASCADE_BIT];
  assign o_dual_mode = mode_cfg_reg[MODE_DUAL_BIT];
  assign o_second_in_primary = mode_cfg_reg[MODE_B_PRIMARY_BIT];
  assign o_second_scaled = mode_cfg_reg[MODE_B_SCALE_BIT];
  assign o_matrix_mode = mode_cfg_reg[MODE_MATRIX_BIT];
  assign o_accum_mode = mode_cfg_reg[MODE_ACCUM_BIT];
endmodule

// >>> hw/ccl_loader_host.sv
// Host end: turns one load command into an address and data word sequence
module ccl_loader_host (
  input wire logic i_clock,
  input wire logic i_rst_b,
  ccl_load_if.host lif,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_cmd_port,
  input wire logic [ccl_pkg::WORD_W-1:0] i_cmd_addr,
  input wire logic [ccl_pkg::ROW_BITS-1:0] i_cmd_data,
  input wire logic i_hold_first,
  input wire logic i_hold_second,
  output logic o_busy
);
  import ccl_pkg::*;

  typedef enum logic {HOST_IDLE, HOST_SEND} ccl_host_state_t;

  ccl_host_state_t state_reg;
  logic port_reg;
  logic [POS_W-1:0] cnt_reg;
  logic [POS_W-1:0] need_reg;
  logic [ROW_BITS-1:0] data_reg;
  logic en_n_reg [NUM_PORTS];
  logic [WORD_W-1:0] word_reg [NUM_PORTS];

  wire start = (state_reg == HOST_IDLE) && i_cmd_valid;
  wire port_hold = port_reg ? i_hold_second : i_hold_first;
  wire step = (state_reg == HOST_SEND) && !port_hold;
  wire done = step && (cnt_reg == need_reg);
  wire [WORD_W-1:0] next_word = data_reg[cnt_reg[2:0]*WORD_W +: WORD_W];

  assign o_cmd_ready = (state_reg == HOST_IDLE);
  assign o_busy = (state_reg == HOST_SEND);
  assign lif.load_enable_first_n = en_n_reg[0];
  assign lif.load_word_first = word_reg[0];
  assign lif.hold_first = i_hold_first;
  assign lif.load_enable_second_n = en_n_reg[1];
  assign lif.load_word_second = word_reg[1];
  assign lif.hold_second = i_hold_second;

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg <= HOST_IDLE;
      port_reg <= 1'b0;
      cnt_reg <= '0;
      need_reg <= '0;
      data_reg <= '0;
    end
    else if (start)
    begin
      state_reg <= HOST_SEND;
      port_reg <= i_cmd_port;
      cnt_reg <= '0;
      need_reg <= ccl_words_needed(ccl_class_t'(i_cmd_addr[CLASS_HI:CLASS_LO]));
      data_reg <= i_cmd_data;
    end
    else if (done)
      state_reg <= HOST_IDLE;
    else if (step)
      cnt_reg <= cnt_reg + POS_W'(1);
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_pins
      wire mine = (port_reg == 1'(p));
      always_ff @(posedge i_clock or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          en_n_reg[p] <= 1'b1;
          word_reg[p] <= WORD_IDLE;
        end
        else if (start && i_cmd_port == 1'(p))
        begin
          en_n_reg[p] <= 1'b0;
          word_reg[p] <= i_cmd_addr;
        end
        else if (done && mine)
        begin
          en_n_reg[p] <= 1'b1;
          word_reg[p] <= WORD_IDLE;
        end
        else if (step && mine)
          word_reg[p] <= next_word;
      end
    end
  endgenerate
endmodule

// >>> bench/ccl_load_checker.sv
// Concurrent checks on the twin load port wires between host and device
module ccl_load_checker (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic load_enable_first_n,
  input wire logic [11:0] load_word_first,
  input wire logic hold_first,
  input wire logic load_enable_second_n,
  input wire logic [11:0] load_word_second,
  input wire logic hold_second
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] taken1_reg, taken2_reg;
  logic [2:0] cls1_reg, cls2_reg;
  logic [3:0] need1, need2;

  // Words per sequence, address included
  function automatic logic [3:0] need_of(input logic [2:0] c);
    return (c == 3'h0) ? 4'h9 : (c[2] ? 4'h5 : 4'h2);
  endfunction

  assign need1 = need_of(cls1_reg);
  assign need2 = need_of(cls2_reg);

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      taken1_reg <= 4'h0;
      taken2_reg <= 4'h0;
      cls1_reg <= 3'h0;
      cls2_reg <= 3'h0;
    end
    else
    begin
      taken1_reg <= load_enable_first_n ? 4'h0 : taken1_reg + {3'h0, !hold_first};
      taken2_reg <= load_enable_second_n ? 4'h0 : taken2_reg + {3'h0, !hold_second};
      cls1_reg <= (!load_enable_first_n && taken1_reg == 4'h0) ? load_word_first[11:9] : cls1_reg;
      cls2_reg <= (!load_enable_second_n && taken2_reg == 4'h0) ? load_word_second[11:9] : cls2_reg;
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  a_hold_freeze_first: assert property (hold_first && !load_enable_first_n |=>
    !load_enable_first_n && $stable(load_word_first)) else $error("port 1 moved under hold");
  a_hold_freeze_second: assert property (hold_second && !load_enable_second_n |=>
    !load_enable_second_n && $stable(load_word_second)) else $error("port 2 moved under hold");
  a_word_count_first: assert property ($rose(load_enable_first_n) |->
    taken1_reg == need1) else $error("port 1 word count wrong");
  a_word_count_second: assert property ($rose(load_enable_second_n) |->
    taken2_reg == need2) else $error("port 2 word count wrong");
  a_closed_quiet_first: assert property (load_enable_first_n |->
    load_word_first == 12'h000) else $error("port 1 word while closed");
  a_closed_quiet_second: assert property (load_enable_second_n |->
    load_word_second == 12'h000) else $error("port 2 word while closed");
  a_count_bound_first: assert property (taken1_reg <= 4'h9) else $error("port 1 overrun");
  a_count_bound_second: assert property (taken2_reg <= 4'h9) else $error("port 2 overrun");

  cover property ($rose(load_enable_first_n) && cls1_reg == 3'h0);
  cover property (hold_first && !load_enable_first_n);
  cover property ($rose(load_enable_second_n) && cls2_reg[2]);
endmodule

// >>> bench/coefficient_config_loader_test.sv
// Directed bench joining the host and device load ends
`define CHK(a, b) \
  begin \
    n_compared++; \
    if ((a) !== (b)) \
    begin \
      n_errors++; \
      $display("ERROR %0t value mismatch", $time); \
    end \
  end

module coefficient_config_loader_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock, i_rst_b, i_cmd_valid, i_cmd_port, i_hold_first, i_hold_second;
  logic [11:0] i_cmd_addr;
  logic [95:0] i_cmd_data, coef;
  logic [7:0] i_coef_row_first, i_coef_row_second;
  logic [3:0] i_reg_sel_first, i_reg_sel_second;
  logic o_cmd_ready, o_busy, o_limit_en_first, o_limit_en_second;
  logic o_cascade_not_last, o_dual_mode, o_second_in_primary, o_second_scaled;
  logic o_matrix_mode, o_accum_mode;
  logic [95:0] o_coef_first, o_coef_second;
  logic [4:0] o_select_first, o_select_second;
  logic [31:0] o_round_first, o_round_second, o_limit_first, o_limit_second;
  logic [5:0] mode_bits;
  int n_errors = 0;
  int n_compared = 0;

  ccl_load_if lif();
  ccl_loader_host i_ccl_loader_host (.i_clock, .i_rst_b, .lif(lif), .i_cmd_valid, .o_cmd_ready,
    .i_cmd_port, .i_cmd_addr, .i_cmd_data, .i_hold_first, .i_hold_second, .o_busy);
  ccl_loader_dev i_ccl_loader_dev (.i_clock, .i_rst_b, .lif(lif), .i_coef_row_first,
    .i_coef_row_second, .i_reg_sel_first, .i_reg_sel_second, .o_coef_first, .o_coef_second,
    .o_select_first, .o_select_second, .o_round_first, .o_round_second, .o_limit_first,
    .o_limit_second, .o_limit_en_first, .o_limit_en_second, .o_cascade_not_last,
    .o_dual_mode, .o_second_in_primary, .o_second_scaled, .o_matrix_mode, .o_accum_mode);
  ccl_load_checker i_ccl_load_checker (.i_clock, .i_rst_b,
    .load_enable_first_n(lif.load_enable_first_n), .load_word_first(lif.load_word_first),
    .hold_first(lif.hold_first), .load_enable_second_n(lif.load_enable_second_n),
    .load_word_second(lif.load_word_second), .hold_second(lif.hold_second));

  assign mode_bits = {o_accum_mode, o_matrix_mode, o_second_scaled, o_second_in_primary,
    o_dual_mode, o_cascade_not_last};

  always #50 i_clock = ~i_clock;

  task automatic end_sim();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One command through the host, then time for commit and registered read
  task automatic send(input logic p, input logic [11:0] a, input logic [95:0] d);
    int k;
    logic [12:0] pins;
    k = 0;
    while (o_cmd_ready !== 1'b1 && k < 50)
    begin
      @(negedge i_clock);
      k++;
    end
    i_cmd_port = p;
    i_cmd_addr = a;
    i_cmd_data = d;
    i_cmd_valid = 1'b1;
    @(negedge i_clock);
    i_cmd_valid = 1'b0;
    pins = p ? {lif.load_enable_second_n, lif.load_word_second} :
      {lif.load_enable_first_n, lif.load_word_first};
    `CHK({o_busy, o_cmd_ready, pins}, {2'h2, 1'b0, a})
    while (o_busy !== 1'b0 && k < 50)
    begin
      @(negedge i_clock);
      k++;
    end
    if (k >= 50)
    begin
      n_errors++;
      end_sim();
    end
    repeat (3) @(negedge i_clock);
  endtask

  initial
  begin
    i_clock = 1'b0;
    i_rst_b = 1'b0;
    {i_cmd_valid, i_cmd_port, i_hold_first, i_hold_second} = 4'h0;
    i_cmd_addr = 12'h000;
    i_cmd_data = 96'h0;
    i_coef_row_first = 8'h0a;
    i_coef_row_second = 8'h0a;
    i_reg_sel_first = 4'hc;
    i_reg_sel_second = 4'h7;
    coef = {12'h143, 12'hf20, 12'h832, 12'h701, 12'h9e3, 12'hc76, 12'h543, 12'h210};
    repeat (5) @(negedge i_clock);
    i_rst_b = 1'b1;
    @(negedge i_clock);
    `CHK({o_limit_en_first, o_limit_en_second, mode_bits}, 8'h00)
    send(1'b0, 12'h204, 96'h3);
    `CHK({o_limit_en_first, o_limit_en_second}, 2'h3)
    send(1'b1, 12'h204, 96'h1);
    `CHK({o_limit_en_first, o_limit_en_second}, 2'h1)
    for (int b = 0; b < 6; b++)
    begin
      send(b[0], 12'h205, 96'(1 << b));
      `CHK(mode_bits, 6'(1 << b))
    end
    send(1'b0, 12'h00a, coef);
    `CHK(o_coef_first, coef)
    send(1'b1, 12'h00a, ~coef);
    `CHK(o_coef_second, ~coef)
    `CHK(o_coef_first, coef)
    send(1'b0, 12'h80c, {48'h0, 12'h076, 12'h083, 12'h0f4, 12'h0a2});
    `CHK(o_round_first, 32'h7683_f4a2)
    send(1'b1, 12'he07, {48'h0, 12'h072, 12'h0a4, 12'h03b, 12'h060});
    `CHK(o_limit_second, 32'h72a4_3b60)
    i_reg_sel_first = 4'h2;
    i_reg_sel_second = 4'h2;
    send(1'b0, 12'h402, 96'hf);
    send(1'b0, 12'h602, 96'h15);
    `CHK(o_select_first, 5'h0f)
    `CHK(o_select_second, 5'h15)
    i_reg_sel_first = 4'h3;
    i_reg_sel_second = 4'h3;
    for (int p = 0; p < 2; p++)
    begin
      i_cmd_addr = (p == 1) ? 12'ha03 : 12'hc03;
      send(p[0], i_cmd_addr, {48'h0, 12'h044, 12'h033, 12'h022, 12'h011});
      fork
        send(p[0], i_cmd_addr, {48'h0, 12'h088, 12'h077, 12'h066, 12'h055});
        begin
          repeat (3) @(negedge i_clock);
          {i_hold_second, i_hold_first} = (p == 1) ? 2'h2 : 2'h1;
          repeat (5) @(negedge i_clock);
          `CHK((p == 1) ? o_round_second : o_limit_first, 32'h4433_2211)
          {i_hold_second, i_hold_first} = 2'h0;
        end
      join
      `CHK((p == 1) ? o_round_second : o_limit_first, 32'h8877_6655)
    end
    end_sim();
  end
endmodule
